//--- verilog/sixsw_defs.svh
`ifndef SIXSW_DEFS_SVH
`define SIXSW_DEFS_SVH

// Frame and counting
`define SIXSW_FRAME_BITS 5'h10
`define SIXSW_CNT_MAX 5'h1f
`define SIXSW_ADDR_LAST 5'h01
`define SIXSW_INSTR_LAST 5'h07

// Addressing bits 7 and 6 of the instruction byte
`define SIXSW_ADDR_OK 2'h2

// Instruction bits 7 to 2
`define SIXSW_OP_WR_STATE 6'h26
`define SIXSW_OP_RD_STATE 6'h25
`define SIXSW_OP_WR_SRC 6'h2a
`define SIXSW_OP_RD_SRC 6'h29
`define SIXSW_OP_RD_FAULT 6'h20

// Reset values and fill bits
`define SIXSW_CTRL_RESET 8'hff
`define SIXSW_LOW_FILL 2'h3
`define SIXSW_TRI_FILL 2'h3
`define SIXSW_NOFAULT 2'h3
`define SIXSW_FAULT_RESET 12'hfff

// Pin bundle at rest: chip select high, everything else low
`define SIXSW_PINS_IDLE 10'h200

`endif

//--- verilog/sixsw_pkg.sv
`default_nettype none
package sixsw_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_DATA,
    ST_REJECT
  } sixsw_state_t;

  typedef enum logic [2:0] {
    CMD_WR_STATE,
    CMD_RD_STATE,
    CMD_WR_SRC,
    CMD_RD_SRC,
    CMD_RD_FAULT,
    CMD_UNUSED
  } sixsw_cmd_t;

  typedef struct packed {
    logic csN;
    logic sclk;
    logic si;
    logic prg;
    logic [5:0] par;
  } sixsw_pins_t;

endpackage
`default_nettype wire

//--- verilog/sixsw_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "sixsw_defs.svh"

module sixsw_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Pins
  input wire sixsw_pkg::sixsw_pins_t pinsAsync,
  output sixsw_pkg::sixsw_pins_t pinsSync
);

  sixsw_pkg::sixsw_pins_t meta_q;
  sixsw_pkg::sixsw_pins_t stable_q;

  // Two flip-flop synchroniser
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= `SIXSW_PINS_IDLE;
      stable_q <= `SIXSW_PINS_IDLE;
    end
    else
    begin
      meta_q <= pinsAsync;
      stable_q <= meta_q;
    end
  end

  assign pinsSync = stable_q;

endmodule
`default_nettype wire

//--- verilog/sixsw_spi_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "sixsw_defs.svh"

// Behaviour
// - Chip select falling: load diagnosis into shifter, start taking data; output driven from the third rising edge.
// - Chip select rising: commit written data, or clear faults on fault read, if frame valid.
// - Chip select high: clock and input ignored, output tri-stated.
// - Input sampled on falling clock edges, output updated after rising edges.
// - Count falling edges; only exactly sixteen makes a frame valid.
// - Input and output data move most significant bit first.
// - Serial bits low mean on; source bits high mean parallel control.
// - Reset clears shifter, turns outputs off, tri-states serial output.
// - Addressed only when bit 7 is one and bit 6 zero; else reject.
// - Serial output stays tri-stated during the first two instruction bits.
// - Chip select high returns the machine to idle; address mismatch holds it in reject until then.
// - Decode five instructions from bits 7 to 2; bits 1 and 0 ignored.
// - First output byte: two tri bits, fault, overtemp, channels 6 and 5.
// - Second byte: register read-back with two ones, or channels 4 to 1.
// - Data byte is discarded on every read instruction.
// - Unused codes write nothing and return the full diagnosis.
// - Fault codes and overtemp clear only after valid sixteen-edge fault read.
// - Registers written only by valid write instruction in sixteen-edge frame.
// - Diagnosis word: six two-bit codes, overtemp bit, common fault bit.
// - Source and serial registers read/write; diagnosis read only.
// - A stored fault code holds until read out, reset or replaced by a newer fault code.
// - Source and serial registers reset to all ones; low bits read one.
module sixsw_spi_slave (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Serial link and parallel pins
  input wire sixsw_pkg::sixsw_pins_t pinsAsync,
  // Serial output pin
  output logic soData,
  output logic soOe,
  // Fault detection side
  input wire logic [5:0][1:0] faultCodeIn,
  input wire logic overtempIn,
  // Power stage drive and fault flag
  output logic [5:0] chanOn,
  output logic faultFlag
);

  //////////////////////////////////////////////////////////////////////////////
  // Instruction decode

  function automatic sixsw_pkg::sixsw_cmd_t decodeCmd(input logic [5:0] op);
    sixsw_pkg::sixsw_cmd_t c;
    case (op)
      `SIXSW_OP_WR_STATE: c = sixsw_pkg::CMD_WR_STATE;
      `SIXSW_OP_RD_STATE: c = sixsw_pkg::CMD_RD_STATE;
      `SIXSW_OP_WR_SRC: c = sixsw_pkg::CMD_WR_SRC;
      `SIXSW_OP_RD_SRC: c = sixsw_pkg::CMD_RD_SRC;
      `SIXSW_OP_RD_FAULT: c = sixsw_pkg::CMD_RD_FAULT;
      default: c = sixsw_pkg::CMD_UNUSED;
    endcase
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection

  sixsw_pkg::sixsw_pins_t pin;
  logic prevCsN_q;
  logic prevSclk_q;
  logic csFall;
  logic csRise;
  logic sclkFall;
  logic sclkRise;

  sixsw_sync u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pinsAsync(pinsAsync),
    .pinsSync(pin)
  );

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prevCsN_q <= 1'b1;
      prevSclk_q <= 1'b0;
    end
    else
    begin
      prevCsN_q <= pin.csN;
      prevSclk_q <= pin.sclk;
    end
  end

  assign csFall = prevCsN_q & ~pin.csN;
  assign csRise = ~prevCsN_q & pin.csN;
  // Clock edges only count while selected
  assign sclkFall = ~pin.csN & ~prevCsN_q & prevSclk_q & ~pin.sclk;
  assign sclkRise = ~pin.csN & ~prevCsN_q & ~prevSclk_q & pin.sclk;

  //////////////////////////////////////////////////////////////////////////////
  // Edge counter and input shifter

  logic [4:0] bitCnt_q;
  logic [15:0] shiftIn_q;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      bitCnt_q <= 5'h00;
    else if (csFall)
      bitCnt_q <= 5'h00;
    else if (sclkFall && bitCnt_q != `SIXSW_CNT_MAX)
      bitCnt_q <= bitCnt_q + 5'h01;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      shiftIn_q <= 16'h0000;
    else if (csFall)
      shiftIn_q <= 16'h0000;
    else if (sclkFall)
      shiftIn_q <= {shiftIn_q[14:0], pin.si};
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command state machine

  sixsw_pkg::sixsw_state_t state_q;
  sixsw_pkg::sixsw_cmd_t cmd_q;
  logic addrMatch;

  assign addrMatch = ({shiftIn_q[0], pin.si} == `SIXSW_ADDR_OK);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      state_q <= sixsw_pkg::ST_IDLE;
    else if (pin.csN)
      state_q <= sixsw_pkg::ST_IDLE;
    else if (csFall)
      state_q <= sixsw_pkg::ST_ADDR;
    else if (sclkFall)
    begin
      case (state_q)
        sixsw_pkg::ST_ADDR:
        begin
          if (bitCnt_q == `SIXSW_ADDR_LAST)
            state_q <= addrMatch ? sixsw_pkg::ST_CMD : sixsw_pkg::ST_REJECT;
        end
        sixsw_pkg::ST_CMD:
        begin
          if (bitCnt_q == `SIXSW_INSTR_LAST)
            state_q <= sixsw_pkg::ST_DATA;
        end
        sixsw_pkg::ST_DATA: state_q <= sixsw_pkg::ST_DATA;
        sixsw_pkg::ST_REJECT: state_q <= sixsw_pkg::ST_REJECT;
        default: state_q <= sixsw_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      cmd_q <= sixsw_pkg::CMD_UNUSED;
    else if (csFall)
      cmd_q <= sixsw_pkg::CMD_UNUSED;
    else if (sclkFall && state_q == sixsw_pkg::ST_CMD && bitCnt_q == `SIXSW_INSTR_LAST)
      cmd_q <= decodeCmd(shiftIn_q[6:1]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [7:0] srcSel_q;
  logic [7:0] serState_q;
  logic frameOk;
  logic clearFault;

  assign frameOk = csRise && state_q == sixsw_pkg::ST_DATA && bitCnt_q == `SIXSW_FRAME_BITS;
  assign clearFault = frameOk && cmd_q == sixsw_pkg::CMD_RD_FAULT;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      serState_q <= `SIXSW_CTRL_RESET;
    else if (frameOk && cmd_q == sixsw_pkg::CMD_WR_STATE)
      serState_q <= {shiftIn_q[7:2], `SIXSW_LOW_FILL};
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      srcSel_q <= `SIXSW_CTRL_RESET;
    else if (frameOk && cmd_q == sixsw_pkg::CMD_WR_SRC)
      srcSel_q <= {shiftIn_q[7:2], `SIXSW_LOW_FILL};
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fault storage

  logic [5:0][1:0] faultCode_q;
  logic overtemp_q;
  logic commonFault;
  logic [15:0] diagWord;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      faultCode_q <= `SIXSW_FAULT_RESET;
    else
    begin
      for (int ch = 0; ch < 6; ch++)
      begin
        if (clearFault)
          faultCode_q[ch] <= faultCode_q[ch] == `SIXSW_NOFAULT ? faultCodeIn[ch] :
                             faultCodeIn[ch];
        else if (faultCodeIn[ch] != `SIXSW_NOFAULT)
          faultCode_q[ch] <= faultCodeIn[ch];
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      overtemp_q <= 1'b0;
    else
      overtemp_q <= overtempIn | (overtemp_q & ~clearFault);
  end

  always_comb
  begin
    commonFault = overtemp_q;
    for (int ch = 0; ch < 6; ch++)
      commonFault = commonFault | (faultCode_q[ch] != `SIXSW_NOFAULT);
  end

  assign diagWord = {`SIXSW_TRI_FILL, commonFault, overtemp_q, faultCode_q};

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      faultFlag <= 1'b0;
    else
      faultFlag <= commonFault;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output shifter

  logic [15:0] shiftOut_q;
  logic [7:0] readByte;
  logic readBack;

  assign readBack = decodeCmd(shiftIn_q[6:1]) == sixsw_pkg::CMD_RD_STATE ||
                    decodeCmd(shiftIn_q[6:1]) == sixsw_pkg::CMD_RD_SRC;
  assign readByte = decodeCmd(shiftIn_q[6:1]) == sixsw_pkg::CMD_RD_STATE ? serState_q :
                    srcSel_q;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      shiftOut_q <= 16'hffff;
    else if (csFall)
      shiftOut_q <= diagWord;
    // First rise presents the leading bit, later rises shift
    else if (sclkRise && bitCnt_q != 5'h00)
      shiftOut_q <= {shiftOut_q[14:0], 1'b1};
    else if (sclkFall && state_q == sixsw_pkg::ST_CMD && bitCnt_q == `SIXSW_INSTR_LAST &&
             readBack)
      shiftOut_q[14:7] <= readByte;
  end

  assign soData = shiftOut_q[15];

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      soOe <= 1'b0;
    else if (pin.csN)
      soOe <= 1'b0;
    else if (sclkRise && (state_q == sixsw_pkg::ST_CMD || state_q == sixsw_pkg::ST_DATA))
      soOe <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power stage control

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      chanOn <= 6'h00;
    else
    begin
      for (int ch = 0; ch < 6; ch++)
        chanOn[ch] <= srcSel_q[ch + 2] ? ~(pin.prg ^ pin.par[ch]) : ~serState_q[ch + 2];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  csHighTri_a: assert property (@(posedge core_clk) disable iff (!nrst)
    pin.csN |=> !soOe)
    else $error("serial output driven while deselected");

  rejectTri_a: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == sixsw_pkg::ST_REJECT |-> !soOe)
    else $error("serial output driven in rejected frame");

  addrDecide_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (sclkFall && state_q == sixsw_pkg::ST_ADDR && bitCnt_q == 5'h01 && !addrMatch)
    |=> state_q == sixsw_pkg::ST_REJECT)
    else $error("mismatched address not rejected");

  earlyTri_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_q == sixsw_pkg::ST_ADDR) |-> !soOe)
    else $error("output driven during address bits");

  cntRestart_a: assert property (@(posedge core_clk) disable iff (!nrst)
    csFall |=> bitCnt_q == 5'h00 && state_q == sixsw_pkg::ST_ADDR)
    else $error("frame did not restart on select");

  stateWrite_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (serState_q != $past(serState_q)) |->
    $past(csRise && bitCnt_q == 5'h10 && cmd_q == sixsw_pkg::CMD_WR_STATE))
    else $error("serial state changed without valid write");

  srcWrite_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (srcSel_q != $past(srcSel_q)) |->
    $past(csRise && bitCnt_q == 5'h10 && cmd_q == sixsw_pkg::CMD_WR_SRC))
    else $error("source select changed without valid write");

  lowBits_a: assert property (@(posedge core_clk) disable iff (!nrst)
    srcSel_q[1:0] == 2'h3 && serState_q[1:0] == 2'h3)
    else $error("unused register bits not one");

  otHold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(overtemp_q) |-> $past(clearFault) && $past(bitCnt_q) == 5'h10)
    else $error("overtemp flag cleared without fault read");

  faultHold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ($past(faultCode_q[2]) != 2'h3 && faultCode_q[2] == 2'h3) |-> $past(clearFault))
    else $error("fault code reverted without read");

  msbOut_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (sclkRise && bitCnt_q != 5'h00) |=> shiftOut_q[15] == $past(shiftOut_q[14]))
    else $error("output not shifted msb first");

endmodule
`default_nettype wire

//--- verilog/placeholder_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- tb/sixsw_master.sv
`timescale 1ns/1ps
`default_nettype none

module sixsw_master (
  // Clock
  input wire logic core_clk,
  // Serial link
  output logic csN,
  output logic sclk,
  output logic si,
  input wire logic soData,
  input wire logic soOe
);
  initial
  begin
    csN = 1'h1;
    sclk = 1'h0;
    si = 1'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  ////////////////////////////////////////
  // One access; sel low keeps chip select high throughout
  task automatic xfer(input logic [15:0] tx, input int nEdges, input bit sel,
    output logic [15:0] rx, output logic [15:0] oe);
    rx = 16'h0;
    oe = 16'h0;
    tick(1);
    csN = !sel;
    tick(8);
    for (int i = 0; i < nEdges; i++)
    begin
      sclk = 1'h1;
      si = (i < 16) ? tx[15 - i] : 1'h0;
      tick(4);
      sclk = 1'h0;
      if (i < 16)
      begin
        rx[15 - i] = soData;
        oe[15 - i] = soOe;
      end
      tick(4);
    end
    csN = 1'h1;
    si = !si;
    tick(8);
  endtask
endmodule

`default_nettype wire

//--- tb/six_channel_switch_spi_slave_test.sv
`timescale 1ns/1ps
`default_nettype none

module six_channel_switch_spi_slave_test;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic prg = 1'h1;
  logic [5:0] par = 6'h3f;
  logic [5:0][1:0] faultCode = 12'hfff;
  logic overtemp = 1'h0;
  logic csN;
  logic sclk;
  logic si;
  logic soData;
  logic soOe;
  logic faultFlag;
  logic [5:0] chanOn;
  logic [15:0] rx;
  logic [15:0] oe;
  logic [7:0] srcM = 8'hff;
  logic [7:0] serM = 8'hff;
  logic [7:0] wrOp [2] = '{8'h9b, 8'hab};
  logic [7:0] rdOp [2] = '{8'h94, 8'ha7};
  logic [7:0] val [2] = '{8'h58, 8'h24};
  logic [7:0] badOp [3] = '{8'h18, 8'hd8, 8'h58};
  sixsw_pkg::sixsw_pins_t pins;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;

  assign pins = {csN, sclk, si, prg, par};

  always #20 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  ////////////////////////////////////////
  // Design and master
  sixsw_spi_slave u_dut (
    .core_clk(core_clk),
    .nrst(nrst),
    .pinsAsync(pins),
    .soData(soData),
    .soOe(soOe),
    .faultCodeIn(faultCode),
    .overtempIn(overtemp),
    .chanOn(chanOn),
    .faultFlag(faultFlag)
  );

  sixsw_master u_master (
    .core_clk(core_clk),
    .csN(csN),
    .sclk(sclk),
    .si(si),
    .soData(soData),
    .soOe(soOe)
  );

  ////////////////////////////////////////
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic acc(input logic [7:0] op, input logic [7:0] dat, input int n = 16,
    input bit sel = 1'b1);
    u_master.xfer({op, dat}, n, sel, rx, oe);
  endtask

  // Addressed frame: bits below the tri pair, enable from the third bit on
  task automatic answer(input logic [7:0] op, input logic [7:0] dat, input logic [13:0] exp);
    acc(op, dat);
    check("serial out", {2'h0, exp}, {2'h0, rx[13:0]});
    check("serial enable", 16'h3fff, oe);
    check("idle enable", 16'h0, {15'h0, soOe});
  endtask

  task automatic onChk();
    logic [5:0] exp;
    exp = (srcM[7:2] & ~({6{prg}} ^ par)) | (~srcM[7:2] & ~serM[7:2]);
    check("power drive", {10'h0, exp}, {10'h0, chanOn});
  endtask

  task automatic doReset();
    nrst = 1'h0;
    srcM = 8'hff;
    serM = 8'hff;
    tick(2);
    check("reset enable", 16'h0, {15'h0, soOe});
    check("reset drive", 16'h0, {10'h0, chanOn});
    nrst = 1'h1;
    tick(4);
  endtask

  ////////////////////////////////////////
  // Sequence
  initial
  begin
    doReset();
    onChk();
    for (int k = 0; k < 2; k++)
    begin
      answer(rdOp[k], 8'h00, {6'h0f, 8'hff});
      answer(wrOp[k], val[k], 14'h0fff);
      if (k == 0)
        serM = val[k] | 8'h03;
      else
        srcM = val[k] | 8'h03;
      onChk();
      acc(wrOp[k], ~val[k], 15);
      acc(wrOp[k], ~val[k], 17);
      answer(rdOp[k], 8'h00, {6'h0f, val[k] | 8'h03});
    end
    prg = 1'h0;
    par = 6'h05;
    tick(8);
    onChk();
    for (int k = 0; k < 3; k++)
    begin
      acc(badOp[k], 8'h00);
      check("serial enable", 16'h0, oe);
    end
    acc(8'h98, 8'h00, 16, 1'b0);
    check("serial enable", 16'h0, oe);
    answer(8'h8c, 8'h00, 14'h0fff);
    answer(8'h94, 8'h00, {6'h0f, serM});
    faultCode[2] = 2'h1;
    overtemp = 1'h1;
    tick(6);
    faultCode[2] = 2'h3;
    overtemp = 1'h0;
    tick(6);
    check("fault flag", 16'h1, {15'h0, faultFlag});
    answer(8'ha4, 8'h00, {6'h3f, srcM});
    acc(8'h80, 8'h00, 15);
    answer(8'h80, 8'hff, 14'h3fdf);
    answer(8'h83, 8'h00, 14'h0fff);
    check("fault flag", 16'h0, {15'h0, faultFlag});
    prg = 1'h1;
    par = 6'h3f;
    doReset();
    answer(8'h94, 8'h00, {6'h0f, 8'hff});
    onChk();
    end_of_test();
  end
endmodule

`default_nettype wire
